// >>> core/interrupt_vector_priority_map.sv
// Interrupt source to vector resolver for default priorities 10 to 44
`include "ivec_params.svh"

// Contract
// - Smallest pending priority number wins
// - Vectors are 16-bit targets below 64 KB
// - Priority 10 shared, vector 0018H
// - Unit 0 transmit 001EH, receive 0020H
// - Priority 13 shared, vector 0022H
// - Unit 1 transmit 0024H, receive 0026H
// - Priority 16 shared, vector 0028H
// - First I2C unit: 17, 002AH
// - Timers 00-03: 18-21, 002CH-0032H
// - A/D 0034H, calendar 0036H, interval 0038H
// - Key return: 25, 003AH, external
// - Unit 3 transmit 003CH, receive 003EH
// - Aux timer 0040H, timers 10-13 0042H-0048H
// - Pins 6-9: 33-36, 004AH-0050H
// - Pin10/comparator0 0052H, pin11/comparator1 0054H
// - Motor timers 0056H and 0058H
// - General timer: 41, 005AH
// - Priority 42 shared, vector 005CH
// - Second I2C 0060H; 44 never requests
// - Reset sources 0000H, break 007EH
module interrupt_vector_priority_map
  import ivec_pkg::*;
#(
  parameter int SLOTS = `IVEC_SLOT_COUNT,
  parameter int SYNC_STAGES = `IVEC_SYNC_STAGES
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Request sources
  input wire periph_req_t periph_req,
  input wire pin_req_t pin_req,
  input wire reset_src_t reset_src,
  input wire logic software_break,
  // Core side
  input wire logic vec_ack,
  output vec_out_t vec_out_r
);

  localparam int PIN_W = $bits(pin_req_t);
  localparam int RST_W = $bits(reset_src_t);

  // Elaboration check: table and encoder are built for 35 slots
  if (SLOTS != `IVEC_SLOT_COUNT || SYNC_STAGES < 2) begin : g_bad_param
    $error("unsupported SLOTS or SYNC_STAGES");
  end

  // Lowest set bit; the smaller index is the more urgent source
  function automatic logic [5:0] first_set(input logic [SLOTS-1:0] v);
    logic [5:0] idx;
    idx = 6'h00;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 6'(i);
      end
    end
    return idx;
  endfunction

  // Pin synchronisers, first stage read only by the next stage
  logic [PIN_W-1:0] pin_sync_r [SYNC_STAGES];
  logic [PIN_W-1:0] pin_sync_nxt [SYNC_STAGES];
  logic [PIN_W-1:0] pin_prev_r;
  logic [PIN_W-1:0] pin_prev_nxt;
  logic [RST_W-1:0] rst_sync_r [SYNC_STAGES];
  logic [RST_W-1:0] rst_sync_nxt [SYNC_STAGES];

  // Next values of the synchroniser chains
  always_comb begin
    pin_sync_nxt[0] = pin_req;
    rst_sync_nxt[0] = reset_src;
    for (int s = 1; s < SYNC_STAGES; s++) begin
      pin_sync_nxt[s] = pin_sync_r[s-1];
      rst_sync_nxt[s] = rst_sync_r[s-1];
    end
    pin_prev_nxt = pin_sync_r[SYNC_STAGES-1];
  end

  // Register the synchronisers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int s = 0; s < SYNC_STAGES; s++) begin
        pin_sync_r[s] <= '0;
        rst_sync_r[s] <= '0;
      end
      pin_prev_r <= '0;
    end else if (clk_en) begin
      for (int s = 0; s < SYNC_STAGES; s++) begin
        pin_sync_r[s] <= pin_sync_nxt[s];
        rst_sync_r[s] <= rst_sync_nxt[s];
      end
      pin_prev_r <= pin_prev_nxt;
    end
  end

  // Pin requests become one-cycle events on the rising level
  pin_req_t pin_evt;
  assign pin_evt = pin_req_t'(pin_sync_r[SYNC_STAGES-1] & ~pin_prev_r);

  // Slot requests, index 0 is default priority 10
  logic [SLOTS-1:0] slot_req;
  always_comb begin
    slot_req[0] = periph_req.serial2_rx_error_req | periph_req.tmr11_upper_byte_req;
    slot_req[1] = periph_req.serial0_tx_req;
    slot_req[2] = periph_req.serial0_rx_req;
    slot_req[3] = periph_req.serial0_rx_error_req | periph_req.tmr01_upper_byte_req;
    slot_req[4] = periph_req.serial1_tx_req;
    slot_req[5] = periph_req.serial1_rx_req;
    slot_req[6] = periph_req.serial1_rx_error_req | periph_req.tmr03_upper_byte_req;
    slot_req[7] = periph_req.i2c_unit0_done_req;
    slot_req[8] = periph_req.tmr00_done_req;
    slot_req[9] = periph_req.tmr01_done_req;
    slot_req[10] = periph_req.tmr02_done_req;
    slot_req[11] = periph_req.tmr03_done_req;
    slot_req[12] = periph_req.adc_done_req;
    slot_req[13] = periph_req.calendar_tick_alarm_req;
    slot_req[14] = periph_req.interval_tick_req;
    slot_req[15] = pin_evt.key_return_req;
    slot_req[16] = periph_req.serial3_tx_req;
    slot_req[17] = periph_req.serial3_rx_req;
    // aux timer, timers 10 to 13
    slot_req[18] = periph_req.aux_timer_req;
    slot_req[19] = periph_req.tmr10_done_req;
    slot_req[20] = periph_req.tmr11_done_req;
    slot_req[21] = periph_req.tmr12_done_req;
    slot_req[22] = periph_req.tmr13_done_req;
    slot_req[26:23] = pin_evt.ext_pin_edge_req[3:0];
    slot_req[27] = pin_evt.ext_pin_edge_req[4] | periph_req.comparator0_req;
    slot_req[28] = pin_evt.ext_pin_edge_req[5] | periph_req.comparator1_req;
    slot_req[29] = periph_req.motor_timer0_req;
    slot_req[30] = periph_req.motor_timer1_req;
    slot_req[31] = periph_req.general_timer_req;
    slot_req[32] = periph_req.serial3_rx_error_req | periph_req.tmr13_upper_byte_req;
    // second I2C; reserved slot input is ignored
    slot_req[33] = periph_req.i2c_unit1_done_req;
    slot_req[`IVEC_SLOT_RESERVED] = 1'b0;
  end

  // Pending flags and the answer register
  logic [SLOTS-1:0] pend_r;
  logic [SLOTS-1:0] pend_nxt;
  logic brk_pend_r;
  logic brk_pend_nxt;
  vec_out_t vec_out_nxt;
  logic [5:0] win_slot;
  logic [5:0] win_prio;
  logic [15:0] win_vec;
  logic win_ext;
  logic [5:0] cur_slot;
  logic rst_any;

  // Winner lookup on the updated pending set
  vector_lookup u_lookup (
    .slot(win_slot),
    .priority_num(win_prio),
    .vector(win_vec),
    .external(win_ext)
  );

  // Slot shown to the core now, for the acknowledge clear
  assign cur_slot = 6'(vec_out_r.priority_num - `IVEC_PRIO_FIRST);
  assign rst_any = |rst_sync_r[SYNC_STAGES-1];

  // Pending update and answer selection
  always_comb begin
    pend_nxt = pend_r;
    brk_pend_nxt = brk_pend_r;
    // Acknowledge clears the presented maskable slot or break; a presented reset stays
    if (vec_ack && vec_out_r.valid && vec_out_r.kind == KIND_MASKABLE) begin
      pend_nxt[cur_slot] = 1'b0;
    end
    if (vec_ack && vec_out_r.valid && vec_out_r.kind == KIND_BREAK) begin
      brk_pend_nxt = 1'b0;
    end
    // set after clear, so a new event is not lost
    pend_nxt = pend_nxt | slot_req;
    brk_pend_nxt = brk_pend_nxt | software_break;
    win_slot = first_set(pend_nxt);
    vec_out_nxt = '{valid: 1'b0, kind: KIND_NONE, vector: 16'h0000, priority_num: 6'h00, external: 1'b0};
    if (rst_any) begin
      vec_out_nxt = '{valid: 1'b1, kind: KIND_RESET, vector: `IVEC_VEC_RESET,
                      priority_num: 6'h00, external: 1'b0};
    end else if (brk_pend_nxt) begin
      // break sits outside the priority scheme
      vec_out_nxt = '{valid: 1'b1, kind: KIND_BREAK, vector: `IVEC_VEC_BREAK,
                      priority_num: 6'h00, external: 1'b0};
    end else if (|pend_nxt) begin
      vec_out_nxt = '{valid: 1'b1, kind: KIND_MASKABLE, vector: win_vec,
                      priority_num: win_prio, external: win_ext};
    end
  end

  // Register pending flags and answer; clk_en low freezes all
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r <= '0;
      brk_pend_r <= 1'b0;
      vec_out_r <= '{valid: 1'b0, kind: KIND_NONE, vector: 16'h0000, priority_num: 6'h00, external: 1'b0};
    end else if (clk_en) begin
      pend_r <= pend_nxt;
      brk_pend_r <= brk_pend_nxt;
      vec_out_r <= vec_out_nxt;
    end
  end

endmodule // interrupt_vector_priority_map

// >>> core/ivec_params.svh
// Timing, slot and vector-address constants for the interrupt vector resolver
`ifndef IVEC_PARAMS_SVH
`define IVEC_PARAMS_SVH

// Default priority numbering of the slots this block resolves
`define IVEC_PRIO_FIRST 6'h0a
`define IVEC_PRIO_LAST 6'h2c
`define IVEC_SLOT_COUNT 35
`define IVEC_PRIO_KEY 6'h19
`define IVEC_PRIO_PIN_FIRST 6'h21
`define IVEC_PRIO_PIN_LAST 6'h26
`define IVEC_SLOT_RESERVED 34

// Vector addresses, each entry one 16-bit word of two bytes
`define IVEC_VEC_SLOT10 16'h0018
`define IVEC_RUN_FIRST 6'h0b
`define IVEC_VEC_RUN_BASE 16'h001e
`define IVEC_TAIL_FIRST 6'h2b
`define IVEC_VEC_TAIL_BASE 16'h0060
`define IVEC_VEC_RESET 16'h0000
`define IVEC_VEC_BREAK 16'h007e

// Flip-flops on every input that arrives from a pin
`define IVEC_SYNC_STAGES 2

`endif

// >>> core/ivec_pkg.sv
// Types shared by the interrupt vector resolver and its lookup table
package ivec_pkg;

  // What the core is being pointed at, one-hot
  typedef enum logic [3:0] {
    KIND_NONE = 4'b0001,
    KIND_RESET = 4'b0010,
    KIND_BREAK = 4'b0100,
    KIND_MASKABLE = 4'b1000
  } vec_kind_t;

  // Same-clock requests from on-chip peripherals, one-cycle pulses
  typedef struct packed {
    logic serial2_rx_error_req;
    logic tmr11_upper_byte_req;
    logic serial0_tx_req;
    logic serial0_rx_req;
    logic serial0_rx_error_req;
    logic tmr01_upper_byte_req;
    logic serial1_tx_req;
    logic serial1_rx_req;
    logic serial1_rx_error_req;
    logic tmr03_upper_byte_req;
    logic i2c_unit0_done_req;
    logic tmr00_done_req;
    logic tmr01_done_req;
    logic tmr02_done_req;
    logic tmr03_done_req;
    logic adc_done_req;
    logic calendar_tick_alarm_req;
    logic interval_tick_req;
    logic serial3_tx_req;
    logic serial3_rx_req;
    logic aux_timer_req;
    logic tmr10_done_req;
    logic tmr11_done_req;
    logic tmr12_done_req;
    logic tmr13_done_req;
    logic comparator0_req;
    logic comparator1_req;
    logic motor_timer0_req;
    logic motor_timer1_req;
    logic general_timer_req;
    logic serial3_rx_error_req;
    logic tmr13_upper_byte_req;
    logic i2c_unit1_done_req;
    logic reserved_slot_44;
  } periph_req_t;

  // Levels from pins: pins 6 to 11 and the key-return line
  typedef struct packed {
    logic key_return_req;
    logic [5:0] ext_pin_edge_req;
  } pin_req_t;

  // Reset-class sources, levels
  typedef struct packed {
    logic pin_reset_src;
    logic power_on_reset_src;
    logic voltage_detect_reset_src;
    logic watchdog_reset_src;
    logic illegal_instr_reset_src;
    logic illegal_access_reset_src;
    logic ram_parity_reset_src;
  } reset_src_t;

  // Answer presented to the core
  typedef struct packed {
    logic valid;
    vec_kind_t kind;
    logic [15:0] vector;
    logic [5:0] priority_num;
    logic external;
  } vec_out_t;

endpackage

// >>> core/vector_lookup.sv
// Slot index to vector address and source class lookup
`include "ivec_params.svh"

module vector_lookup
  import ivec_pkg::*;
(
  // Slot index, 0 is default priority 10
  input wire logic [5:0] slot,
  // Result
  output logic [5:0] priority_num,
  output logic [15:0] vector,
  output logic external
);

  // Address of a priority number; the run breaks after 10 and before 43
  function automatic logic [15:0] vec_of(input logic [5:0] prio);
    logic [15:0] off;
    off = 16'h0000;
    if (prio >= `IVEC_TAIL_FIRST) begin
      off = {9'h000, 6'(prio - `IVEC_TAIL_FIRST), 1'b0};
      vec_of = `IVEC_VEC_TAIL_BASE + off;
    end else if (prio >= `IVEC_RUN_FIRST) begin
      off = {9'h000, 6'(prio - `IVEC_RUN_FIRST), 1'b0};
      vec_of = `IVEC_VEC_RUN_BASE + off;
    end else begin
      vec_of = `IVEC_VEC_SLOT10;
    end
  endfunction

  // Table lookup
  always_comb begin
    priority_num = 6'(slot + `IVEC_PRIO_FIRST);
    vector = vec_of(priority_num);
    external = (priority_num == `IVEC_PRIO_KEY) ||
               ((priority_num >= `IVEC_PRIO_PIN_FIRST) && (priority_num <= `IVEC_PRIO_PIN_LAST));
  end

endmodule // vector_lookup

// >>> test/ivec_core_model.sv
// Behavioural processor core that takes and acknowledges vectors
module ivec_core_model
  import ivec_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bench control
  input wire logic take_en,
  input wire logic [3:0] lag,
  // Resolver side
  input wire vec_out_t vec_out_r,
  output logic vec_ack,
  output logic [15:0] took_vec_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;

  // One-cycle ack; wait restarts after it so a stale answer is never taken twice
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vec_ack <= 1'b0;
      wait_r <= 4'h0;
      took_vec_r <= 16'h0000;
    end else begin
      vec_ack <= 1'b0;
      // Take the vector at the edge the resolver samples the ack, not one edge early
      if (vec_ack && vec_out_r.valid) begin
        took_vec_r <= vec_out_r.vector;
      end
      if (vec_ack || !take_en || !vec_out_r.valid) begin
        wait_r <= 4'h0;
      end else if (wait_r >= lag) begin
        vec_ack <= 1'b1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule // ivec_core_model

// >>> test/ivec_map_props.sv
// Checker for the resolver answer port
module ivec_map_props
  import ivec_pkg::*;
#(
  parameter int SLOTS = 35,
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Sources
  input wire periph_req_t periph_req,
  input wire pin_req_t pin_req,
  input wire reset_src_t reset_src,
  input wire logic software_break,
  // Core side
  input wire logic vec_ack,
  input wire vec_out_t vec_out_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Shorthands for the shown answer
  wire logic is_mask = vec_out_r.valid && vec_out_r.kind == KIND_MASKABLE;
  wire logic [5:0] pn = vec_out_r.priority_num;
  wire logic [15:0] vn = vec_out_r.vector;

  // Reset levels gone long enough to clear the sync chain
  sequence s_quiet;
    (reset_src == '0 && clk_en)[*4];
  endsequence

  property p_vec_word;
    vec_out_r.valid |-> !vn[0] && vn <= 16'h007e;
  endproperty
  a_vec_word: assert property (p_vec_word)
    else $error("vector odd or beyond table");
  property p_prio_range;
    is_mask |-> pn >= 6'h0a && pn <= 6'h2b;
  endproperty
  a_prio_range: assert property (p_prio_range)
    else $error("priority outside 10 to 43");
  property p_vec_map;
    is_mask |-> vn == (pn == 6'h0a ? 16'h0018 : pn == 6'h2b ? 16'h0060 : 16'h001e + 16'({pn - 6'h0b, 1'b0}));
  endproperty
  a_vec_map: assert property (p_vec_map)
    else $error("vector does not match priority");
  property p_ext_flag;
    is_mask |-> vec_out_r.external == (pn == 6'h19 || (pn >= 6'h21 && pn <= 6'h26));
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("external flag wrong");
  property p_break_vec;
    vec_out_r.valid && vec_out_r.kind == KIND_BREAK |-> vn == 16'h007e && pn == 6'h00;
  endproperty
  a_break_vec: assert property (p_break_vec)
    else $error("break vector wrong");
  property p_reset_vec;
    vec_out_r.valid && vec_out_r.kind == KIND_RESET |-> vn == 16'h0000 && pn == 6'h00;
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset vector wrong");
  property p_break_taken;
    s_quiet ##0 (software_break) |=> vec_out_r.valid && vec_out_r.kind == KIND_BREAK;
  endproperty
  a_break_taken: assert property (p_break_taken)
    else $error("break not shown");
  property p_break_ack;
    vec_ack && clk_en && vec_out_r.valid && vec_out_r.kind == KIND_BREAK && !software_break
      |=> vec_out_r.kind != KIND_BREAK;
  endproperty
  a_break_ack: assert property (p_break_ack)
    else $error("break kept after ack");
  property p_top_slot;
    s_quiet ##0 (!vec_out_r.valid && periph_req.serial2_rx_error_req && !software_break) |=> is_mask && pn == 6'h0a;
  endproperty
  a_top_slot: assert property (p_top_slot)
    else $error("priority 10 not shown");
endmodule // ivec_map_props

bind interrupt_vector_priority_map ivec_map_props #(.SLOTS(SLOTS), .SYNC_STAGES(SYNC_STAGES)) ivec_map_props_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .periph_req(periph_req), .pin_req(pin_req),
  .reset_src(reset_src), .software_break(software_break), .vec_ack(vec_ack), .vec_out_r(vec_out_r));

// >>> test/tb_interrupt_vector_priority_map.sv
// Self-checking bench for the interrupt vector resolver
module tb_interrupt_vector_priority_map
  import ivec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus and observed signals
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic software_break = 1'b0;
  logic take_en = 1'b0;
  logic [3:0] lag = 4'h0;
  logic vec_ack;
  logic [15:0] took_vec_r;
  periph_req_t periph_req = '0;
  pin_req_t pin_req = '0;
  reset_src_t reset_src = '0;
  vec_out_t vec_out_r;
  int n_errors = 0;
  int total_checks = 0;
  // Priorities of periph_req bits 33 down to 1
  logic [5:0] ptab [33] = '{6'h0a, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h10, 6'h11, 6'h12,
    6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h25, 6'h26,
    6'h27, 6'h28, 6'h29, 6'h2a, 6'h2a, 6'h2b};

  always #4 sys_clk = ~sys_clk;

  interrupt_vector_priority_map interrupt_vector_priority_map_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .periph_req(periph_req), .pin_req(pin_req), .reset_src(reset_src),
    .software_break(software_break), .vec_ack(vec_ack), .vec_out_r(vec_out_r));
  ivec_core_model ivec_core_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .take_en(take_en), .lag(lag),
    .vec_out_r(vec_out_r), .vec_ack(vec_ack), .took_vec_r(took_vec_r));

  function automatic logic [26:0] shown();
    return {vec_out_r.valid, vec_out_r.kind, vec_out_r.vector, vec_out_r.priority_num};
  endfunction
  // Two-byte entries from 001EH up, two odd slots at the ends
  function automatic logic [15:0] vec_of(input logic [5:0] p);
    if (p == 6'h0a) return 16'h0018;
    if (p == 6'h2b) return 16'h0060;
    return 16'h001e + 16'({p - 6'h0b, 1'b0});
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [26:0] got, input logic [26:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Bounded wait for the shown valid level
  task automatic wait_valid(input logic lvl);
    for (int i = 0; i < 40 && vec_out_r.valid !== lvl; i++) @(negedge sys_clk);
    if (vec_out_r.valid !== lvl) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, vec_out_r.valid, lvl);
      print_verdict();
    end
  endtask

  // One source alone, then the core takes it promptly
  task automatic run_slot(input periph_req_t pr, input pin_req_t pn, input logic [5:0] p);
    @(posedge sys_clk);
    periph_req <= pr;
    pin_req <= pn;
    @(posedge sys_clk);
    periph_req <= '0;
    wait_valid(1'b1);
    check(shown(), {1'b1, KIND_MASKABLE, vec_of(p), p});
    check(27'(vec_out_r.external), 27'(p == 6'h19 || (p >= 6'h21 && p <= 6'h26)));
    @(posedge sys_clk);
    take_en <= 1'b1;
    wait_valid(1'b0);
    @(posedge sys_clk);
    take_en <= 1'b0;
    pin_req <= '0;
    step(4);
  endtask

  // Pending together, served smallest first, shared and repeated merged
  task automatic prio_order();
    periph_req_t r;
    logic [15:0] got [$];
    logic [15:0] exp [4] = '{16'h0022, 16'h002c, 16'h0034, 16'h0048};
    r = '0;
    r.tmr13_done_req = 1'b1;
    r.tmr00_done_req = 1'b1;
    r.adc_done_req = 1'b1;
    r.serial0_rx_error_req = 1'b1;
    r.tmr01_upper_byte_req = 1'b1;
    @(posedge sys_clk);
    periph_req <= r;
    r = '0;
    r.tmr00_done_req = 1'b1;
    @(posedge sys_clk);
    periph_req <= r;
    step(1);
    check(shown(), {1'b1, KIND_MASKABLE, 16'h0022, 6'h0d});
    @(posedge sys_clk);
    periph_req <= '0;
    lag <= 4'h3;
    take_en <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(negedge sys_clk);
      // Taken word lands at the edge that samples the ack
      if (vec_ack === 1'b1) begin
        @(negedge sys_clk);
        got.push_back(took_vec_r);
      end
    end
    @(posedge sys_clk);
    take_en <= 1'b0;
    lag <= 4'h0;
    check(27'(got.size()), 27'h4);
    for (int i = 0; i < 4 && i < got.size(); i++) check(27'(got[i]), 27'(exp[i]));
  endtask

  // Slot 44 and a frozen clock enable raise nothing
  task automatic quiet_cases();
    periph_req_t r;
    r = '0;
    r.reserved_slot_44 = 1'b1;
    @(posedge sys_clk);
    periph_req <= r;
    r = '0;
    r.tmr00_done_req = 1'b1;
    @(posedge sys_clk);
    periph_req <= r;
    clk_en <= 1'b0;
    @(posedge sys_clk);
    periph_req <= '0;
    clk_en <= 1'b1;
    step(4);
    check(shown(), {1'b0, KIND_NONE, 16'h0000, 6'h00});
  endtask

  // Break, then every reset source outranks it and survives an ack
  task automatic break_and_reset();
    @(posedge sys_clk);
    software_break <= 1'b1;
    @(posedge sys_clk);
    software_break <= 1'b0;
    step(1);
    check(shown(), {1'b1, KIND_BREAK, 16'h007e, 6'h00});
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      reset_src <= reset_src_t'(7'h01 << i);
      // Core stays off until reset shows, else it would ack the break
      step(4);
      check(shown(), {1'b1, KIND_RESET, 16'h0000, 6'h00});
      @(posedge sys_clk);
      take_en <= 1'b1;
      step(8);
      check(shown(), {1'b1, KIND_RESET, 16'h0000, 6'h00});
      @(posedge sys_clk);
      take_en <= 1'b0;
      reset_src <= '0;
      step(5);
      check(shown(), {1'b1, KIND_BREAK, 16'h007e, 6'h00});
    end
    @(posedge sys_clk);
    take_en <= 1'b1;
    wait_valid(1'b0);
    @(posedge sys_clk);
    take_en <= 1'b0;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    step(1);
    check(shown(), {1'b0, KIND_NONE, 16'h0000, 6'h00});
    step(4);
    for (int i = 0; i < 33; i++) run_slot(periph_req_t'(34'h200000000 >> i), '0, ptab[i]);
    for (int i = 0; i < 7; i++) run_slot('0, pin_req_t'(7'h01 << i), i == 6 ? 6'h19 : 6'h21 + 6'(i));
    prio_order();
    quiet_cases();
    break_and_reset();
    print_verdict();
  end
endmodule // tb_interrupt_vector_priority_map
